// ### rtl/wdog_pkg.sv
// Constants, register map and state types of the software watchdog.
// Assumes one 100 MHz clock and a synchronous, active-low reset.
// How it works
// - 16-bit up-counter steps once every 24 or 384 clock cycles.
// - Rate comes through a divide-by-2 and an optional divide-by-16 stage.
// - Any reset disables the watchdog and zeroes counter and registers, except that warm reset keeps priority bit 6.
// - Once running it cannot be stopped except by a warm or cold reset.
// - Setting the start/refresh flag while disabled starts counting.
// - Expiry status rises as soon as the counter holds 0x7cff.
// - Expiry status sets priority bit 6 and requests a chip reset.
// - Expiry status falls on reset or when the counter leaves 0x7cff.
// - Start within 12 cycles of refresh flag reloads; otherwise no reload.
// - Valid refresh loads counter from reload register and clears refresh flag in the same cycle.
// - Refresh flag is bit 6 at 0xa8, reset zero, cleared 12 cycles after set.
// - Reload register 0x86: bit 7 selects divide-by-16, bits 6..0 reload high byte.
// - Start/refresh flag is bit 6 of enable register 1, cleared after 12 cycles.
// - Expiry bit survives the watchdog reset; software reads and clears it.
package wdog_pkg;

  localparam int          ADDR_W         = 10;
  localparam int          DATA_W         = 32;
  localparam int          COUNT_W        = 16;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_RELOAD     = 8'h86;
  localparam logic [7:0]  IDX_ENABLE0    = 8'ha8;
  localparam logic [7:0]  IDX_PRIORITY0  = 8'ha9;
  localparam logic [7:0]  IDX_ENABLE1    = 8'hb8;
  localparam logic [7:0]  IDX_IRQ_STATUS = 8'hc0;
  localparam logic [7:0]  IDX_IRQ_CLEAR  = 8'hc1;
  localparam logic [7:0]  IDX_IRQ_ENABLE = 8'hc2;
  localparam logic [7:0]  IDX_COUNT      = 8'hc3;

  localparam int          FLAG_BIT       = 6;
  localparam int          PSEL_BIT       = 7;
  localparam int          RELOAD_MSB     = 6;
  localparam logic [7:0]  REG_RESET      = 8'h00;

  localparam logic [15:0] EXPIRY_STATE   = 16'h7cff;

  // Base divider gives 24 and 384 cycles after the 2 and 16 stages
  localparam int          BASE_DIV       = 12;
  localparam int          DIV_FAST       = 2;
  localparam int          DIV_SLOW       = 16;
  localparam int          FLAG_HOLD      = 12;

  localparam int          EV_EXPIRY      = 0;
  localparam int          EV_RELOAD      = 1;
  localparam int          EV_ABANDON     = 2;
  localparam int          EV_W           = 3;

  typedef enum logic {
    wd_idle,
    wd_running
  } wd_mode_type;

  typedef enum logic {
    bus_wait,
    bus_done
  } bus_phase_type;

  typedef struct packed {
    bus_phase_type        phase;
    logic                 waitreq;
    logic [7:0]           rdata;
    wd_mode_type          mode;
    logic [15:0]          count;
    logic                 expiry;
    logic [7:0]           enable0;
    logic [7:0]           enable1;
    logic [7:0]           priority0;
    logic [7:0]           reload;
    logic [3:0]           refresh_hold;
    logic [3:0]           start_hold;
    logic [EV_W-1:0]      irq_status;
    logic [EV_W-1:0]      irq_enable;
    logic                 irq;
  } core_state_type;

  typedef struct packed {
    logic [3:0]           base;
    logic                 half;
    logic [3:0]           sixteenth;
    logic                 tick;
  } prescale_state_type;

endpackage : wdog_pkg

// ### rtl/wdog_prescaler.sv
// Prescaler chain of the software watchdog: base, divide-by-2, divide-by-16.
// Assumes run is held for as long as the watchdog counts.
module wdog_prescaler
(
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic run,
  input  wire logic slow_select,
  output logic      tick
);

  wdog_pkg::prescale_state_type state_ff;
  wdog_pkg::prescale_state_type nxt_state;

  logic base_end;

  always_comb
  begin
    nxt_state      = state_ff;
    nxt_state.tick = 1'b0;
    base_end       = state_ff.base == 4'(wdog_pkg::BASE_DIV - 1);
    if (run)
    begin
      nxt_state.base = base_end ? 4'h0 : state_ff.base + 4'h1;
      if (base_end)
      begin
        nxt_state.half = ~state_ff.half;
        if (state_ff.half)
        begin
          nxt_state.sixteenth = state_ff.sixteenth + 4'h1;
          nxt_state.tick      = !slow_select ||
                                state_ff.sixteenth == 4'(wdog_pkg::DIV_SLOW - 1);
        end
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign tick = state_ff.tick;

endmodule : wdog_prescaler

// ### rtl/software_watchdog_timer.sv
// Software watchdog core with its register file on an Avalon-MM slave.
// Assumes a master that holds each request until waitrequest is seen low.
//
// The Avalon-MM register port was left to the implementer.
module software_watchdog_timer
(
  input  wire logic                          clock,
  input  wire logic                          resetn,
  input  wire logic                          cold_resetn,
  input  wire logic [wdog_pkg::ADDR_W-1:0]   address,
  input  wire logic                          read,
  input  wire logic                          write,
  input  wire logic [wdog_pkg::DATA_W-1:0]   writedata,
  input  wire logic [3:0]                    byteenable,
  output logic      [wdog_pkg::DATA_W-1:0]   readdata,
  output logic                               waitrequest,
  output logic                               expiry_status,
  output logic                               chip_reset_request,
  output logic                               irq
);

  wdog_pkg::core_state_type state_ff;
  wdog_pkg::core_state_type nxt_state;

  logic                        tick;
  logic [7:0]                  index;
  logic [7:0]                  wdata;
  logic                        wr_hit;
  logic [wdog_pkg::EV_W-1:0]   events;
  logic [wdog_pkg::EV_W-1:0]   clear_mask;
  logic                        refresh_pending;

  // Word index from byte address; misaligned addresses never match
  function automatic logic [7:0] reg_index
  (
    input logic [wdog_pkg::ADDR_W-1:0] addr
  );
    reg_index = (addr[1:0] == 2'h0) ? addr[9:2] : 8'hff;
  endfunction : reg_index

  function automatic logic is_reg
  (
    input logic [7:0] idx,
    input logic [7:0] which
  );
    is_reg = idx == which;
  endfunction : is_reg

  wdog_prescaler u_prescaler
  (
    .clock       (clock),
    .resetn      (resetn),
    .run         (state_ff.mode == wdog_pkg::wd_running),
    .slow_select (state_ff.reload[wdog_pkg::PSEL_BIT]),
    .tick        (tick)
  );

  always_comb
  begin
    nxt_state       = state_ff;
    events          = '0;
    clear_mask      = '0;
    index           = reg_index(address);
    wdata           = writedata[7:0];
    wr_hit          = 1'b0;
    refresh_pending = state_ff.enable0[wdog_pkg::FLAG_BIT];

    // Bus handshake: take request, answer one edge later
    unique case (state_ff.phase)
      wdog_pkg::bus_wait:
      begin
        if (read || write)
        begin
          nxt_state.phase   = wdog_pkg::bus_done;
          nxt_state.waitreq = 1'b0;
          nxt_state.rdata   = 8'h00;
          if (read)
          begin
            if (is_reg(index, wdog_pkg::IDX_RELOAD))
              nxt_state.rdata = state_ff.reload;
            else if (is_reg(index, wdog_pkg::IDX_ENABLE0))
              nxt_state.rdata = state_ff.enable0;
            else if (is_reg(index, wdog_pkg::IDX_PRIORITY0))
              nxt_state.rdata = state_ff.priority0;
            else if (is_reg(index, wdog_pkg::IDX_ENABLE1))
              nxt_state.rdata = state_ff.enable1;
            else if (is_reg(index, wdog_pkg::IDX_IRQ_STATUS))
              nxt_state.rdata = 8'(state_ff.irq_status);
            else if (is_reg(index, wdog_pkg::IDX_IRQ_ENABLE))
              nxt_state.rdata = 8'(state_ff.irq_enable);
            else if (is_reg(index, wdog_pkg::IDX_COUNT))
              nxt_state.rdata = state_ff.count[15:8];
          end
        end
      end
      wdog_pkg::bus_done:
      begin
        nxt_state.phase   = wdog_pkg::bus_wait;
        nxt_state.waitreq = 1'b1;
        wr_hit            = write && byteenable[0];
      end
    endcase

    // Hardware ends each flag after its hold time
    if (state_ff.enable0[wdog_pkg::FLAG_BIT])
    begin
      if (state_ff.refresh_hold == 4'h0)
      begin
        nxt_state.enable0[wdog_pkg::FLAG_BIT] = 1'b0;
        events[wdog_pkg::EV_ABANDON]       = 1'b1;
      end
      else
      begin
        nxt_state.refresh_hold = state_ff.refresh_hold - 4'h1;
      end
    end
    if (state_ff.enable1[wdog_pkg::FLAG_BIT])
    begin
      if (state_ff.start_hold == 4'h0)
        nxt_state.enable1[wdog_pkg::FLAG_BIT] = 1'b0;
      else
        nxt_state.start_hold = state_ff.start_hold - 4'h1;
    end

    // Counter advances on each prescaler tick
    if (state_ff.mode == wdog_pkg::wd_running && tick)
      nxt_state.count = state_ff.count + 16'h0001;

    if (wr_hit)
    begin
      if (is_reg(index, wdog_pkg::IDX_RELOAD))
      begin
        nxt_state.reload = wdata;
      end
      else if (is_reg(index, wdog_pkg::IDX_ENABLE0))
      begin
        nxt_state.enable0[7]   = wdata[7];
        nxt_state.enable0[5:0] = wdata[5:0];
        if (wdata[wdog_pkg::FLAG_BIT])
        begin
          // Setting again restarts the window
          nxt_state.enable0[wdog_pkg::FLAG_BIT] = 1'b1;
          nxt_state.refresh_hold = 4'(wdog_pkg::FLAG_HOLD - 1);
          events[wdog_pkg::EV_ABANDON] = 1'b0;
        end
      end
      else if (is_reg(index, wdog_pkg::IDX_ENABLE1))
      begin
        nxt_state.enable1[7]   = wdata[7];
        nxt_state.enable1[5:0] = wdata[5:0];
        if (wdata[wdog_pkg::FLAG_BIT])
        begin
          nxt_state.enable1[wdog_pkg::FLAG_BIT] = 1'b1;
          nxt_state.start_hold = 4'(wdog_pkg::FLAG_HOLD - 1);
          if (state_ff.mode == wdog_pkg::wd_idle)
          begin
            nxt_state.mode = wdog_pkg::wd_running;
          end
          else if (refresh_pending)
          begin
            nxt_state.count = {1'b0, state_ff.reload[wdog_pkg::RELOAD_MSB:0],
                               8'h00};
            nxt_state.enable0[wdog_pkg::FLAG_BIT] = 1'b0;
            events[wdog_pkg::EV_RELOAD]           = 1'b1;
            events[wdog_pkg::EV_ABANDON]          = 1'b0;
          end
        end
      end
      else if (is_reg(index, wdog_pkg::IDX_PRIORITY0))
      begin
        nxt_state.priority0[7]   = wdata[7];
        nxt_state.priority0[5:0] = wdata[5:0];
        if (!wdata[wdog_pkg::FLAG_BIT])
          nxt_state.priority0[wdog_pkg::FLAG_BIT] = 1'b0;
      end
      else if (is_reg(index, wdog_pkg::IDX_IRQ_CLEAR))
      begin
        clear_mask = wdata[wdog_pkg::EV_W-1:0];
      end
      else if (is_reg(index, wdog_pkg::IDX_IRQ_ENABLE))
      begin
        nxt_state.irq_enable = wdata[wdog_pkg::EV_W-1:0];
      end
    end

    // Mode never returns to idle here: only reset stops the watchdog

    // Compare follows the counter so status tracks its state directly
    nxt_state.expiry = nxt_state.mode == wdog_pkg::wd_running &&
                       nxt_state.count == wdog_pkg::EXPIRY_STATE;
    if (nxt_state.expiry)
    begin
      nxt_state.priority0[wdog_pkg::FLAG_BIT] = 1'b1;
      if (!state_ff.expiry)
        events[wdog_pkg::EV_EXPIRY] = 1'b1;
    end

    // Event set wins over a clear in the same cycle
    nxt_state.irq_status = (state_ff.irq_status & ~clear_mask) | events;
    nxt_state.irq        = |(nxt_state.irq_status & nxt_state.irq_enable);
  end

  // Expiry bit is kept through a warm reset, dropped by cold reset
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      state_ff         <= '0;
      state_ff.waitreq <= 1'b1;
      state_ff.priority0[wdog_pkg::FLAG_BIT] <= cold_resetn &&
                                                state_ff.priority0[wdog_pkg::FLAG_BIT];
    end
    else if (!cold_resetn)
    begin
      state_ff         <= '0;
      state_ff.waitreq <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign readdata           = {24'h000000, state_ff.rdata};
  assign waitrequest        = state_ff.waitreq;
  assign expiry_status      = state_ff.expiry;
  assign chip_reset_request = state_ff.expiry;
  assign irq                = state_ff.irq;

endmodule : software_watchdog_timer

// ### bench/software_watchdog_timer_chk.sv
// Checker for the software watchdog: bus handshake, expiry output and reset quiet state.
// Bound to the top module by the bench; sees only its ports.
module software_watchdog_timer_chk
(
  input wire logic                        clock,
  input wire logic                        resetn,
  input wire logic                        cold_resetn,
  input wire logic [wdog_pkg::ADDR_W-1:0] address,
  input wire logic                        read,
  input wire logic                        write,
  input wire logic [wdog_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0]                  byteenable,
  input wire logic [wdog_pkg::DATA_W-1:0] readdata,
  input wire logic                        waitrequest,
  input wire logic                        expiry_status,
  input wire logic                        chip_reset_request,
  input wire logic                        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!resetn);

  wait_ans_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered in one cycle");
  wait_one_a: assert property ($fell(waitrequest) |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  wait_idle_a: assert property (!read && !write && waitrequest |=> waitrequest)
    else $error("waitrequest fell without a request");
  rd_upper_a: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  unmapped_rd_a: assert property (read && waitrequest && address == 10'h3fc |=> readdata == 32'h0)
    else $error("unmapped read not zero");
  rst_quiet_a: assert property ($rose(resetn) |-> waitrequest && !expiry_status && !irq)
    else $error("outputs not quiet after reset");
  exp_pair_a: assert property (expiry_status == chip_reset_request)
    else $error("reset request differs from expiry");
  exp_hold_a: assert property ($rose(expiry_status) |-> expiry_status [*8])
    else $error("expiry dropped too early");
  exp_fall_a: assert property ($rose(expiry_status) |-> ##[1:385] !expiry_status)
    else $error("expiry held after counter moved");
  exp_latch_a: assert property (read && waitrequest && expiry_status && $past(expiry_status)
    && address == {wdog_pkg::IDX_PRIORITY0, 2'b00} |=> readdata[6])
    else $error("expiry latch not set");

  cover property ($rose(expiry_status));
  cover property (read && !waitrequest);
  cover property (write && !waitrequest);
endmodule : software_watchdog_timer_chk

// ### bench/software_watchdog_timer_bench.sv
// Self-checking bench of the software watchdog: registers, refresh, abandon, expiry, resets.
// Drives the Avalon-MM port itself; a monitor compares each read against a queue.
module software_watchdog_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, resetn, cold_resetn, read, write, waitrequest;
  logic        expiry_status, chip_reset_request, irq;
  logic [9:0]  address;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable, be_sel;
  logic [31:0] exp_q[$];
  logic [7:0]  r;
  logic [7:0]  idle_idx [7] = '{8'h86, 8'ha8, 8'ha9, 8'hb8, 8'hc0, 8'hc3, 8'hff};
  int          n_fail, cmp_count, n;

  software_watchdog_timer i_dut (.clock(clock), .resetn(resetn), .cold_resetn(cold_resetn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .expiry_status(expiry_status), .chip_reset_request(chip_reset_request), .irq(irq));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic stop_test();
    if (n_fail == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // A read passes its expected value in d
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    address    <= {idx, 2'b00};
    write      <= w;
    read       <= !w;
    writedata  <= {24'h0, d};
    byteenable <= be_sel;
    if (!w)
      exp_q.push_back({24'h0, d});
    do
    begin
      @(posedge clock);
      k++;
    end
    while (waitrequest !== 1'b0 && k < 40);
    if (k >= 40)
    begin
      n_fail++;
      stop_test();
    end
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask : bus

  task automatic refresh(input logic [7:0] rel);
    bus(1'b1, wdog_pkg::IDX_RELOAD, rel);
    bus(1'b1, wdog_pkg::IDX_ENABLE0, 8'h40);
    bus(1'b1, wdog_pkg::IDX_ENABLE1, 8'h40);
  endtask : refresh

  always @(posedge clock)
    if (read === 1'b1 && waitrequest === 1'b0 && exp_q.size() > 0)
      check(readdata, exp_q.pop_front(), "readdata");

  initial
  begin
    {resetn, cold_resetn, read, write, address, writedata} = '0;
    byteenable = 4'hf;
    be_sel = 4'hf;
    n_fail = 0;
    cmp_count = 0;
    void'($urandom(32'h689383d2));
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    cold_resetn <= 1'b1;
    @(posedge clock);
    foreach (idle_idx[i])
      bus(1'b0, idle_idx[i], 8'h00);
    be_sel = 4'he;
    bus(1'b1, wdog_pkg::IDX_RELOAD, 8'h55);
    be_sel = 4'hf;
    bus(1'b0, wdog_pkg::IDX_RELOAD, 8'h00);
    bus(1'b1, wdog_pkg::IDX_IRQ_ENABLE, 8'h07);
    bus(1'b1, wdog_pkg::IDX_ENABLE1, 8'h40);
    bus(1'b0, wdog_pkg::IDX_ENABLE1, 8'h40);
    repeat (12) @(posedge clock);
    bus(1'b0, wdog_pkg::IDX_ENABLE1, 8'h00);
    r = 8'($urandom % 124);
    refresh(r);
    bus(1'b0, wdog_pkg::IDX_COUNT, r);
    bus(1'b0, wdog_pkg::IDX_ENABLE0, 8'h00);
    bus(1'b0, wdog_pkg::IDX_IRQ_STATUS, 8'h02);
    check({31'h0, irq}, 32'h1, "irq");
    bus(1'b1, wdog_pkg::IDX_RELOAD, r ^ 8'h01);
    bus(1'b1, wdog_pkg::IDX_IRQ_ENABLE, 8'h00);
    bus(1'b1, wdog_pkg::IDX_IRQ_CLEAR, 8'h07);
    bus(1'b1, wdog_pkg::IDX_ENABLE0, 8'h40);
    bus(1'b0, wdog_pkg::IDX_ENABLE0, 8'h40);
    repeat (14) @(posedge clock);
    bus(1'b0, wdog_pkg::IDX_ENABLE0, 8'h00);
    bus(1'b1, wdog_pkg::IDX_ENABLE1, 8'h40);
    bus(1'b0, wdog_pkg::IDX_COUNT, r);
    bus(1'b0, wdog_pkg::IDX_IRQ_STATUS, 8'h04);
    check({31'h0, irq}, 32'h0, "irq");
    bus(1'b1, wdog_pkg::IDX_IRQ_CLEAR, 8'h07);
    bus(1'b1, wdog_pkg::IDX_IRQ_ENABLE, 8'h01);
    bus(1'b1, wdog_pkg::IDX_ENABLE1, 8'h00);
    refresh(8'hfc);
    repeat (256 * 24 + 40) @(posedge clock);
    check({31'h0, expiry_status}, 32'h0, "expiry_status");
    // Slow rate has stepped only a few times; fast rate would be past 0x7d00
    bus(1'b0, wdog_pkg::IDX_COUNT, 8'h7c);
    refresh(8'h7c);
    repeat (254 * 24 - 20) @(posedge clock);
    check({31'h0, expiry_status}, 32'h0, "expiry_status");
    n = 0;
    while (expiry_status !== 1'b1 && n < 100)
    begin
      @(posedge clock);
      n++;
    end
    check({31'h0, expiry_status}, 32'h1, "expiry_status");
    check({31'h0, chip_reset_request}, 32'h1, "chip_reset_request");
    bus(1'b0, wdog_pkg::IDX_PRIORITY0, 8'h40);
    check({31'h0, irq}, 32'h1, "irq");
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    check({31'h0, expiry_status}, 32'h0, "expiry_status");
    bus(1'b0, wdog_pkg::IDX_PRIORITY0, 8'h40);
    bus(1'b1, wdog_pkg::IDX_PRIORITY0, 8'h00);
    bus(1'b0, wdog_pkg::IDX_PRIORITY0, 8'h00);
    bus(1'b0, wdog_pkg::IDX_ENABLE1, 8'h00);
    stop_test();
  end
endmodule : software_watchdog_timer_bench

bind software_watchdog_timer software_watchdog_timer_chk i_chk (.clock(clock), .resetn(resetn),
  .cold_resetn(cold_resetn), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .expiry_status(expiry_status),
  .chip_reset_request(chip_reset_request), .irq(irq));
